// [src/dtp_axil_regs.sv]
// AXI4-Lite slave: register file of the down timer
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module dtp_axil_regs
   import dtp_pkg::*;
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Timer side
   input  wire logic [7:0]  live_count,
   input  wire logic [7:0]  prescale_count,
   input  wire logic        run_clear,
   output dtp_cfg_t         cfg,
   output dtp_load_t        count_write
);

   typedef struct packed {
      logic        aw_held;
      logic [3:0]  aw_addr;
      logic        w_held;
      logic [7:0]  w_data;
      logic        w_lane;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      logic [7:0]  ctl1;
      logic [7:0]  ctl2;
      logic [7:0]  duty;
   } dtp_rg_state_t;

   dtp_rg_state_t state;
   dtp_rg_state_t next_state;
   logic          do_write;

   // Offset decode of a byte address
   function automatic logic [2:0] decode(input logic [3:0] a);
      if (a == {REG_COUNT_IDX, 2'h0})
         return 3'h1;
      else if (a == {REG_CTRL1_IDX, 2'h0})
         return 3'h2;
      else if (a == {REG_CTRL2_IDX, 2'h0})
         return 3'h3;
      else if (a == {REG_DUTY_IDX, 2'h0})
         return 3'h4;
      else
         return 3'h0;
   endfunction

   assign s_axi_awready = !state.aw_held && !state.bvalid;
   assign s_axi_wready  = !state.w_held && !state.bvalid;
   assign s_axi_arready = !state.rvalid;
   assign do_write      = state.aw_held && state.w_held && !state.bvalid;

   // ========================================================
   // Bus and register update
   always_comb
   begin
      next_state = state;
      count_write = '{load: 1'b0, load_value: 8'h00};
      if (s_axi_awvalid && s_axi_awready)
      begin
         next_state.aw_held = 1'b1;
         next_state.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         next_state.w_held = 1'b1;
         next_state.w_data = s_axi_wdata[7:0];
         next_state.w_lane = s_axi_wstrb[0];
      end
      if (run_clear)
         next_state.ctl1[CTL1_RUN] = 1'b0;                       // [R06]
      if (do_write)
      begin
         next_state.aw_held = 1'b0;
         next_state.w_held  = 1'b0;
         next_state.bvalid  = 1'b1;
         next_state.bresp   = RESP_OKAY;
         case (decode(state.aw_addr))
            3'h1:
            begin
               count_write.load       = state.w_lane;             // [R02]
               count_write.load_value = state.w_data;
            end
            3'h2:
               if (state.w_lane)
                  next_state.ctl1 = state.w_data & CTL1_MASK;
            3'h3:
               if (state.w_lane)
                  next_state.ctl2 = state.w_data & CTL2_MASK;
            3'h4:
               if (state.w_lane)
                  next_state.duty = state.w_data;
            default:
               next_state.bresp = RESP_SLVERR;
         endcase
      end
      if (state.bvalid && s_axi_bready)
         next_state.bvalid = 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
         next_state.rvalid = 1'b1;
         next_state.rresp  = RESP_OKAY;
         next_state.rdata  = 32'h0000_0000;
         if (s_axi_araddr == {REG_COUNT_IDX, 2'h0})
            next_state.rdata[7:0] = live_count;                   // [R01]
         else if (s_axi_araddr == {REG_CTRL1_IDX, 2'h0})
            next_state.rdata[7:0] = state.ctl1;
         else if (s_axi_araddr == {REG_CTRL2_IDX, 2'h0})
            next_state.rdata[7:0] = state.ctl2;
         else if (s_axi_araddr == {REG_DUTY_IDX, 2'h0})
            next_state.rdata[7:0] = 8'h00;
         else if (s_axi_araddr == REG_PSCV_ADDR)
            next_state.rdata[7:0] = prescale_count;
         else
            next_state.rresp = RESP_SLVERR;
      end
      else if (state.rvalid && s_axi_rready)
         next_state.rvalid = 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state      <= '0;
         state.ctl1 <= CTL1_RESET;
         state.ctl2 <= CTL2_RESET;
         state.duty <= DUTY_RESET;
      end
      else
         state <= next_state;
   end

   assign s_axi_bvalid = state.bvalid;
   assign s_axi_bresp  = state.bresp;
   assign s_axi_rvalid = state.rvalid;
   assign s_axi_rresp  = state.rresp;
   assign s_axi_rdata  = state.rdata;

   always_comb
   begin
      cfg.run_enable            = state.ctl1[CTL1_RUN];
      cfg.auto_reload_select    = state.ctl1[CTL1_RELOAD];
      cfg.one_shot_select       = state.ctl1[CTL1_ONESHOT];
      cfg.pwm_active_low        = state.ctl1[CTL1_PWM_AL];
      cfg.pwm_output_enable     = state.ctl1[CTL1_PWM_OE];
      cfg.prescale_ratio_select = state.ctl2[CTL2_PS_LSB +: 3];
      cfg.prescale_disable_n    = state.ctl2[CTL2_PS_DIS_N];
      cfg.count_edge_select     = state.ctl2[CTL2_EDGE];
      cfg.count_source_select   = state.ctl2[CTL2_SOURCE];
      cfg.pwm_duty_compare      = state.duty;
   end

endmodule

// [src/dtp_down_timer.sv]
// Top: 8-bit down timer with reload, prescaler and PWM output
//
// Contract
// [R01] Count register read returns live counter
// [R02] Count write loads reload and counter
// [R03] Non-stop, no reload: underflow loads 0xff
// [R04] Non-stop, reload: underflow loads reload value
// [R05] Non-stop mode never halts on underflow
// [R06] One-shot counts once to zero, stops
// [R07] Reload select ignored in one-shot mode
// [R08] Polarity bit one makes PWM active low
// [R09] PWM enable routes waveform to pin six
// [R10] Prescaler divides by two to 256
// [R11] Source bit picks instruction or external clock
// [R12] Edge bit picks falling or rising input
// [R13] Change ratio only while prescaler disabled
// [R14] PWM active from duty match to underflow
// [R15] Decrement per tick only while enabled
// [R16] Underflow gives one-cycle event pulse
`timescale 1ns/1ps
module dtp_down_timer
   import dtp_pkg::*;
#(
   parameter int PRESCALE_WIDTH = 8
)
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite slave
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Count input
   input  wire logic        external_count_input,
   // Port pin six
   input  wire logic        gpio_pin_six_out,
   input  wire logic        gpio_pin_six_oe,
   output logic             portb_pin_six_out,
   output logic             portb_pin_six_oe,
   // Event
   output logic             underflow_flag
);

   typedef struct packed {
      logic [7:0] count;
      logic [7:0] reload;
      logic       pwm_active;
      logic       underflow;
      logic       pin_out;
      logic       pin_oe;
   } dtp_tm_state_t;

   dtp_tm_state_t state;
   dtp_tm_state_t next_state;
   dtp_cfg_t      cfg;
   dtp_load_t     count_write;
   logic          tick;
   logic          run_clear;
   logic [7:0]    prescale_count;
   logic          level;

   // ========================================================
   // Register file
   dtp_axil_regs u_regs (
      .aclk           (aclk),
      .aresetn        (aresetn),
      .s_axi_awaddr   (s_axi_awaddr),
      .s_axi_awvalid  (s_axi_awvalid),
      .s_axi_awready  (s_axi_awready),
      .s_axi_wdata    (s_axi_wdata),
      .s_axi_wstrb    (s_axi_wstrb),
      .s_axi_wvalid   (s_axi_wvalid),
      .s_axi_wready   (s_axi_wready),
      .s_axi_bresp    (s_axi_bresp),
      .s_axi_bvalid   (s_axi_bvalid),
      .s_axi_bready   (s_axi_bready),
      .s_axi_araddr   (s_axi_araddr),
      .s_axi_arvalid  (s_axi_arvalid),
      .s_axi_arready  (s_axi_arready),
      .s_axi_rdata    (s_axi_rdata),
      .s_axi_rresp    (s_axi_rresp),
      .s_axi_rvalid   (s_axi_rvalid),
      .s_axi_rready   (s_axi_rready),
      .live_count     (state.count),
      .prescale_count (prescale_count),
      .run_clear      (run_clear),
      .cfg            (cfg),
      .count_write    (count_write)
   );

   // ========================================================
   // Prescaler, free only while timer runs and not disabled
   dtp_prescaler #(
      .WIDTH (PRESCALE_WIDTH)
   ) u_prescaler (
      .aclk                 (aclk),
      .aresetn              (aresetn),
      .enable               (cfg.run_enable && !cfg.prescale_disable_n),
      .source_select        (cfg.count_source_select),
      .edge_select          (cfg.count_edge_select),
      .ratio_select         (cfg.prescale_ratio_select),
      .external_count_input (external_count_input),
      .tick                 (tick),
      .count_value          (prescale_count)
   );

   // ========================================================
   // Counter, reload and PWM
   always_comb
   begin
      next_state = state;
      next_state.underflow = 1'b0;
      run_clear = 1'b0;
      if (count_write.load)
      begin
         next_state.reload = count_write.load_value;             // [R02]
         next_state.count  = count_write.load_value;             // [R02]
         next_state.pwm_active = 1'b0;
      end
      else if (cfg.run_enable && tick)                            // [R15]
      begin
         if (state.count == 8'h00)
         begin
            next_state.underflow  = 1'b1;                         // [R16]
            next_state.pwm_active = 1'b0;                         // [R14]
            if (cfg.one_shot_select)                              // [R07]
               run_clear = 1'b1;                                  // [R06]
            else if (cfg.auto_reload_select)
               next_state.count = state.reload;                   // [R04] [R05]
            else
               next_state.count = COUNT_TOP;                      // [R03] [R05]
         end
         else
         begin
            next_state.count = state.count - 8'h01;               // [R15]
            if (state.count - 8'h01 == cfg.pwm_duty_compare)
               next_state.pwm_active = 1'b1;                      // [R14]
         end
      end
      level = state.pwm_active ^ cfg.pwm_active_low;              // [R08]
      if (cfg.pwm_output_enable)                                  // [R09]
      begin
         next_state.pin_out = level;
         next_state.pin_oe  = 1'b1;
      end
      else
      begin
         next_state.pin_out = gpio_pin_six_out;
         next_state.pin_oe  = gpio_pin_six_oe;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state        <= '0;
         state.count  <= COUNT_RESET;
         state.reload <= COUNT_RESET;
      end
      else
         state <= next_state;
   end

   assign portb_pin_six_out = state.pin_out;
   assign portb_pin_six_oe  = state.pin_oe;
   assign underflow_flag    = state.underflow;

endmodule

// [src/dtp_pkg.sv]
// Package: register map, field layout and types of the down timer
package dtp_pkg;

   // ========================================================
   // Register offsets (index; byte address is four times it; REG_PSCV_ADDR is a byte address)
   localparam logic [1:0] REG_COUNT_IDX  = 2'h0;
   localparam logic [1:0] REG_CTRL1_IDX  = 2'h1;
   localparam logic [1:0] REG_CTRL2_IDX  = 2'h2;
   localparam logic [1:0] REG_DUTY_IDX   = 2'h3;
   localparam logic [3:0] REG_PSCV_ADDR  = 4'h4;

   // ========================================================
   // Control one fields
   localparam int CTL1_RUN       = 0;
   localparam int CTL1_RELOAD    = 1;
   localparam int CTL1_ONESHOT   = 2;
   localparam int CTL1_PWM_AL    = 6;
   localparam int CTL1_PWM_OE    = 7;
   localparam logic [7:0] CTL1_RESET = 8'h00;
   localparam logic [7:0] CTL1_MASK  = 8'hc7;

   // ========================================================
   // Control two fields
   localparam int CTL2_PS_LSB    = 0;
   localparam int CTL2_PS_DIS_N  = 3;
   localparam int CTL2_EDGE      = 4;
   localparam int CTL2_SOURCE    = 5;
   localparam logic [7:0] CTL2_RESET = 8'h3f;
   localparam logic [7:0] CTL2_MASK  = 8'h3f;

   // ========================================================
   // Counter, reset and bus response constants
   localparam logic [7:0] COUNT_TOP    = 8'hff;
   localparam logic [7:0] COUNT_RESET  = 8'hff;
   localparam logic [7:0] DUTY_RESET   = 8'h00;
   localparam logic [7:0] PSCV_RESET   = 8'hff;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;

   // ========================================================
   // Types
   typedef struct packed {
      logic       run_enable;
      logic       auto_reload_select;
      logic       one_shot_select;
      logic       pwm_active_low;
      logic       pwm_output_enable;
      logic [2:0] prescale_ratio_select;
      logic       prescale_disable_n;
      logic       count_edge_select;
      logic       count_source_select;
      logic [7:0] pwm_duty_compare;
   } dtp_cfg_t;

   typedef struct packed {
      logic       load;
      logic [7:0] load_value;
   } dtp_load_t;

endpackage

// [src/dtp_prescaler.sv]
// Prescaler: picks count source and edge, divides by 2 to 256
`timescale 1ns/1ps
module dtp_prescaler
   import dtp_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   // Clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // Configuration
   input  wire logic             enable,
   input  wire logic             source_select,
   input  wire logic             edge_select,
   input  wire logic [2:0]       ratio_select,
   // Count input and result
   input  wire logic             external_count_input,
   output logic                  tick,
   output logic [WIDTH-1:0]      count_value
);

   typedef struct packed {
      logic             ext_prev;
      logic [WIDTH-1:0] cnt;
   } dtp_ps_state_t;

   dtp_ps_state_t state;
   dtp_ps_state_t next_state;
   logic          raw_tick;
   logic [WIDTH-1:0] next_cnt;
   logic [WIDTH-1:0] tap_mask;

   // ========================================================
   // Source and edge selection
   always_comb
   begin
      if (source_select)                                          // [R11]
         raw_tick = edge_select                                   // [R12]
                  ? (state.ext_prev & ~external_count_input)
                  : (~state.ext_prev & external_count_input);
      else
         raw_tick = 1'b1;
   end

   // ========================================================
   // Divider
   always_comb
   begin
      next_cnt   = state.cnt - WIDTH'(1);
      tap_mask   = WIDTH'((9'h002 << ratio_select) - 9'h001);     // [R10]
      next_state = state;
      next_state.ext_prev = external_count_input;
      tick = 1'b0;
      if (enable && raw_tick)
      begin
         next_state.cnt = next_cnt;
         tick = ((next_cnt & tap_mask) == tap_mask);              // [R10]
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         state <= '{ext_prev: 1'b0, cnt: '1};
      else
         state <= next_state;
   end

   assign count_value = state.cnt;

endmodule

// [testbench/dtp_down_timer_monitor.sv]
// Checker: bus answers, event pulse and pin routing of the timer
`timescale 1ns/1ps
module dtp_monitor
   import dtp_pkg::*;
(
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Register bus
   input wire logic [3:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Pin and event
   input wire logic        gpio_pin_six_out,
   input wire logic        gpio_pin_six_oe,
   input wire logic        portb_pin_six_out,
   input wire logic        portb_pin_six_oe,
   input wire logic        underflow_flag
);
   logic [3:0] waddr_q;
   logic       wbit_q;
   logic       route_q;

   // ========================================================
   // Shadow of the pin routing bit
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         waddr_q <= 4'h0;
         wbit_q  <= 1'b0;
         route_q <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
            waddr_q <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready)
            wbit_q <= s_axi_wdata[CTL1_PWM_OE];
         if ($rose(s_axi_bvalid) && waddr_q == 4'h4)
            route_q <= wbit_q;
      end
   end

   // ========================================================
   // Properties
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_wr_answer;
      !s_axi_bvalid ##[1:2] s_axi_bvalid;
   endsequence

   property p_wr_answer;
      s_wr_take |=> s_wr_answer;
   endproperty
   a_wr_answer: assert property (p_wr_answer)
      else $error("write answer late");
   property p_wr_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_wr_hold: assert property (p_wr_hold)
      else $error("write answer dropped");
   property p_wr_block;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_wr_block: assert property (p_wr_block)
      else $error("write taken while answer pending");
   property p_rd_answer;
      s_axi_arvalid && s_axi_arready |=> ##[0:1] s_axi_rvalid;
   endproperty
   a_rd_answer: assert property (p_rd_answer)
      else $error("read answer late");
   property p_rd_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data not held");
   property p_uf_pulse;
      underflow_flag |=> !underflow_flag;
   endproperty
   a_uf_pulse: assert property (p_uf_pulse)
      else $error("underflow event longer than a cycle");
   property p_reset_idle;
      $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !underflow_flag
         && !portb_pin_six_oe;
   endproperty
   a_reset_idle: assert property (p_reset_idle)
      else $error("outputs busy after reset");
   property p_route_on;
      route_q && $past(route_q) |-> portb_pin_six_oe;
   endproperty
   a_route_on: assert property (p_route_on)
      else $error("pin not driven while waveform routed");
   property p_route_off;
      !route_q && !$past(route_q) && $past(aresetn) |->
         portb_pin_six_out == $past(gpio_pin_six_out)
         && portb_pin_six_oe == $past(gpio_pin_six_oe);
   endproperty
   a_route_off: assert property (p_route_off)
      else $error("pin does not follow general drive");
endmodule

bind dtp_down_timer dtp_monitor u_mon (.*);

// [testbench/tb_dtp_down_timer.sv]
// Testbench: self-checking run of the down timer with PWM
`timescale 1ns/1ps
module tb_dtp_down_timer;
   import dtp_pkg::*;
   // ========================================================
   // Design ports and bench state
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready;
   logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic        external_count_input, gpio_pin_six_out, gpio_pin_six_oe;
   logic        portb_pin_six_out, portb_pin_six_oe, underflow_flag, act;
   logic [7:0]  v, w;
   int          n_errors, total_checks, cyc, n, a;

   dtp_down_timer #(.PRESCALE_WIDTH(8)) DUT (.*);

   initial
   begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         n_errors++;
         complete_run();
      end
   end

   // ========================================================
   // Tasks
   task automatic complete_run;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Answer ready raised after a random wait, held until answered
   task automatic wr(input logic [3:0] ad, input logic [7:0] dt);
      int k;
      k = $urandom_range(4, 0);
      @(posedge aclk);
      s_axi_awaddr  <= ad;
      s_axi_wdata   <= {24'h0, dt};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= (k == 0);
      do
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
         k--;
         if (k == 0)
            s_axi_bready <= 1'b1;
      end while (!(s_axi_bready && s_axi_bvalid));
      s_axi_bready <= 1'b0;
      chk("bresp", s_axi_bresp, RESP_OKAY);
   endtask

   task automatic rchk(input string nm, input logic [3:0] ad,
                       input logic [31:0] exp);
      int k;
      k = $urandom_range(3, 0);
      @(posedge aclk);
      s_axi_araddr  <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= (k == 0);
      do
      begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
         k--;
         if (k == 0)
            s_axi_rready <= 1'b1;
      end while (!(s_axi_rready && s_axi_rvalid));
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
      chk("rresp", s_axi_rresp, RESP_OKAY);
      chk(nm, d, exp);
   endtask

   // Cycles to the next underflow, and active pin cycles on the way
   task automatic span;
      n = 0;
      a = 0;
      do
      begin
         @(posedge aclk);
         n++;
         a += int'(portb_pin_six_out === act);
      end while (!underflow_flag && n < 5000);
      chk("underflow", underflow_flag, 1'b1);
   endtask

   // ========================================================
   // Main sequence
   initial
   begin
      void'($urandom(94));
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      {s_axi_rready, external_count_input, aresetn} = '0;
      {gpio_pin_six_out, gpio_pin_six_oe, act} = '0;
      s_axi_wstrb = 4'hf;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rchk("count", 4'h0, 8'hff);
      rchk("ctl1", 4'h4, CTL1_RESET);
      rchk("ctl2", 4'h8, CTL2_RESET);
      rchk("duty", 4'hc, 8'h00);
      v = 8'($urandom_range(255, 1));
      wr(4'h8, 8'h08);
      wr(4'h8, 8'h00);
      wr(4'h0, v);
      repeat (40) @(posedge aclk);
      rchk("hold", 4'h0, v);
      for (int r = 0; r < 8; r++)
      begin
         v = 8'($urandom_range(3, 0));
         wr(4'h8, {5'h01, r[2:0]});
         wr(4'h8, {5'h00, r[2:0]});
         wr(4'h0, v);
         wr(4'h4, 8'h03);
         span();
         span();
         chk("period", n, (v + 1) << (r + 1));
         if (r == 7)
            rchk("reload", 4'h0, v);
      end
      wr(4'h4, 8'h01);
      wr(4'h8, 8'h08);
      wr(4'h8, 8'h00);
      span();
      span();
      chk("free period", n, 512);
      wr(4'h8, 8'h0f);
      wr(4'h8, 8'h07);
      wr(4'h0, 8'h01);
      span();
      rchk("wrap", 4'h0, 8'hff);
      wr(4'h8, 8'h08);
      wr(4'h8, 8'h00);
      wr(4'h4, 8'h00);
      wr(4'h0, 8'($urandom_range(15, 1)));
      wr(4'h4, 8'h07);
      span();
      rchk("stopped", 4'h4, 8'h06);
      repeat (600) @(posedge aclk);
      rchk("one shot", 4'h0, 8'h00);
      for (int p = 0; p < 2; p++)
      begin
         v = 8'($urandom_range(5, 0));
         act = ~p[0];
         wr(4'hc, v);
         wr(4'h0, 8'h07);
         wr(4'h4, {1'b1, p[0], 6'h03});
         span();
         span();
         chk("active", a, (v + 1) * 2);
         chk("pin oe", portb_pin_six_oe, 1'b1);
      end
      wr(4'h4, 8'h01);
      repeat (4)
      begin
         w = 8'($urandom);
         @(posedge aclk);
         {gpio_pin_six_out, gpio_pin_six_oe} <= w[1:0];
         repeat (2) @(posedge aclk);
         chk("gpio", {portb_pin_six_out, portb_pin_six_oe}, w[1:0]);
      end
      for (int e = 0; e < 2; e++)
      begin
         wr(4'h8, {3'b001, e[0], 4'h8});
         wr(4'h8, {3'b001, e[0], 4'h0});
         wr(4'h0, 8'h40);
         repeat (200) @(posedge aclk);
         rchk("ext idle", 4'h0, 8'h40);
         repeat (16)
         begin
            repeat (4) @(posedge aclk);
            external_count_input <= ~external_count_input;
         end
         repeat (8) @(posedge aclk);
         rchk("ext count", 4'h0, 8'h3c);
      end
      complete_run();
   end
endmodule
